/* rtl/mis_pkg.sv */
package mis_pkg;
    // address layout and bus codes
    localparam logic [2:0] ADDR_UPPER = 3'h4;       // upper bits 100
    localparam logic [4:0] HS_CODE = 5'h01;         // master code 00001xxx
    localparam logic [7:0] GCALL_ADDR = 8'h00;      // general call, write
    localparam logic [7:0] GCALL_RESET = 8'h06;     // general call reset command
    localparam logic [7:0] CFG_PTR = 8'h00;         // configuration register pointer
    // configuration word fields
    localparam int CFG_RST_BIT = 15;
    localparam int MODE_LSB = 0;
    localparam int SHUNT_AVERAGING_FIELD_LSB = 3;
    localparam int BUS_VOLT_AVERAGING_FIELD_LSB = 7;
    localparam logic [15:0] CFG_RESET = 16'h399f;
    // strap level codes seen by the decoder
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_VS = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    localparam logic [1:0] STRAP_SCL = 2'h3;
    // mode field codes
    localparam logic [2:0] MODE_PDOWN = 3'h0;
    localparam logic [2:0] MODE_ADC_OFF = 3'h4;
    localparam logic [2:0] MODE_CONT_BOTH = 3'h7;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int RECOVER_US = 40;
    localparam int RECOVER_CYC = RECOVER_US * CLK_MHZ;
    localparam int TIMEOUT_MS = 28;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int FILT_FS_CYC = 10;                // about 50 ns spikes
    localparam int FILT_HS_CYC = 2;                 // about 10 ns spikes
    typedef enum logic [2:0] {
        MIS_IDLE = 3'b000,
        MIS_ADDR = 3'b001,
        MIS_PTR = 3'b010,
        MIS_WDATA = 3'b011,
        MIS_RDATA = 3'b100,
        MIS_GCALL = 3'b101,
        MIS_SKIP = 3'b110
    } mis_state_t;
endpackage

/* rtl/mis_slave.sv */
module mis_slave
    import mis_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int RECOVER_CYCLES = RECOVER_CYC
)(
    input wire logic i_sys_clk,                   // system clock
    input wire logic i_sys_rst,                   // synchronous reset, high
    input wire logic i_scl,                       // clock line level
    input wire logic i_sda,                       // data line level
    output logic o_sda_out,                       // data drive value, always 0
    output logic o_sda_oe,                        // pulls data line low
    input wire logic [1:0] i_addr_select_low_pin, // low strap level code
    input wire logic [1:0] i_addr_select_high_pin,// high strap level code
    input wire logic [15:0] i_rd_word,            // word at the pointer
    output logic [7:0] o_ptr,                     // register pointer
    output logic o_wr_stb,                        // pulse: word write
    output logic [15:0] o_wr_word,                // written word
    output logic [15:0] o_cfg,                    // configuration register
    output logic o_conv_start,                    // pulse: start conversion
    output logic o_conv_shunt,                    // conversion includes shunt
    output logic o_conv_bus,                      // conversion includes bus
    input wire logic i_conv_done,                 // pulse: all work done
    output logic o_conversion_done_flag,          // ready flag
    output logic o_results_valid,                 // recovery elapsed
    output logic o_hs_mode                        // high-speed filters on
);
    import mis_pkg::*;

    // refuse counts the counters cannot serve
    if (TIMEOUT_CYCLES < 1 || RECOVER_CYCLES < 1)
    begin : g_bad_counts
        $error("mis_slave: counts must be positive");
    end

    // ------------------------------------------------------------
    // line synchronisers and glitch filters
    // ------------------------------------------------------------
    logic [1:0] scl_sync_q, sda_sync_q;
    logic scl_q, sda_q, scl_prev_q, sda_prev_q;
    logic [3:0] scl_cnt_q, sda_cnt_q;
    logic hs_q;
    logic [3:0] filt_len;

    assign filt_len = hs_q ? 4'(FILT_HS_CYC) : 4'(FILT_FS_CYC);

    // two flops per line before anything looks at it
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
        end
    end

    // a level must hold filt_len cycles before it is accepted
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_cnt_q <= 4'h0;
            sda_cnt_q <= 4'h0;
        end
        else
        begin
            if (scl_sync_q[1] == scl_q)
                scl_cnt_q <= 4'h0;
            else if (scl_cnt_q + 4'h1 >= filt_len)
            begin
                scl_q <= scl_sync_q[1];
                scl_cnt_q <= 4'h0;
            end
            else
                scl_cnt_q <= scl_cnt_q + 4'h1;
            if (sda_sync_q[1] == sda_q)
                sda_cnt_q <= 4'h0;
            else if (sda_cnt_q + 4'h1 >= filt_len)
            begin
                sda_q <= sda_sync_q[1];
                sda_cnt_q <= 4'h0;
            end
            else
                sda_cnt_q <= sda_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
        end
    end

    logic scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_rise = scl_q & ~scl_prev_q;
    assign scl_fall = ~scl_q & scl_prev_q;
    assign start_ev = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
    assign stop_ev = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

    // ------------------------------------------------------------
    // bus stuck-low timeout
    // ------------------------------------------------------------
    logic [31:0] low_cnt_q;
    logic timeout_q;

    // counting stops at the limit so a stuck bus fires one reset only
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || (scl_q && sda_q))
        begin
            low_cnt_q <= 32'h0;
            timeout_q <= 1'b0;
        end
        else if (low_cnt_q == 32'(TIMEOUT_CYCLES))
            timeout_q <= 1'b0;
        else
        begin
            low_cnt_q <= low_cnt_q + 32'h1;
            timeout_q <= (low_cnt_q + 32'h1 == 32'(TIMEOUT_CYCLES));
        end
    end

    // ------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------
    mis_state_t state_q;
    logic [7:0] shift_q;
    logic [3:0] bit_q;
    logic ack_phase_q, rnw_q, byte_idx_q, first_q, sda_oe_q;
    logic [6:0] my_addr_q;
    logic [7:0] ptr_q, hi_q;
    logic wr_stb_q, gc_rst_q;
    logic [15:0] wr_word_q;
    logic [7:0] rx_byte;

    assign rx_byte = {shift_q[6:0], sda_q};

    // strap decode taken at each start
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
            my_addr_q <= {ADDR_UPPER, 4'h0};
        else if (start_ev)
            my_addr_q <= {ADDR_UPPER, i_addr_select_high_pin,
                          i_addr_select_low_pin};
    end

    // general call reset and timeout return the link to idle; a soft reset
    // leaves it alone so the ack of its own word still completes
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || timeout_q || gc_rst_q)
        begin
            state_q <= MIS_IDLE;
            bit_q <= 4'h0;
            ack_phase_q <= 1'b0;
            sda_oe_q <= 1'b0;
            rnw_q <= 1'b0;
            byte_idx_q <= 1'b0;
            first_q <= 1'b0;
            shift_q <= 8'h0;
            hi_q <= 8'h0;
            wr_stb_q <= 1'b0;
            gc_rst_q <= 1'b0;
            wr_word_q <= 16'h0;
        end
        else
        begin
            wr_stb_q <= 1'b0;
            gc_rst_q <= 1'b0;
            if (stop_ev)
            begin
                state_q <= MIS_IDLE;
                sda_oe_q <= 1'b0;
            end
            else if (start_ev)
            begin
                state_q <= MIS_ADDR;
                sda_oe_q <= 1'b0;
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
            end
            else if (state_q != MIS_IDLE && scl_rise)
            begin
                if (ack_phase_q)
                begin
                    // in a read the master's ack after the upper byte decides whether to go on; after the lower byte the read always ends
                    if (state_q == MIS_RDATA && (sda_q || byte_idx_q))
                        state_q <= MIS_SKIP;
                end
                else
                begin
                    if (state_q != MIS_RDATA)
                        shift_q <= rx_byte;
                    bit_q <= bit_q + 4'h1;
                end
            end
            else if (state_q != MIS_IDLE && scl_fall)
            begin
                if (ack_phase_q)
                begin
                    ack_phase_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    bit_q <= 4'h0;
                    if (state_q == MIS_RDATA)
                    begin
                        // upper byte after the address ack, lower after the master's ack
                        first_q <= 1'b0;
                        byte_idx_q <= ~first_q;
                        if (first_q)
                        begin
                            sda_oe_q <= ~i_rd_word[15];
                            shift_q <= {i_rd_word[14:8], 1'b0};
                        end
                        else
                        begin
                            sda_oe_q <= ~i_rd_word[7];
                            shift_q <= {i_rd_word[6:0], 1'b0};
                        end
                    end
                end
                else if (bit_q == 4'h8)
                begin
                    ack_phase_q <= 1'b1;
                    case (state_q)
                        MIS_ADDR:
                        begin
                            rnw_q <= shift_q[0];
                            byte_idx_q <= 1'b0;
                            first_q <= 1'b1;
                            if (shift_q[7:1] == my_addr_q)
                            begin
                                sda_oe_q <= 1'b1;
                                state_q <= shift_q[0] ? MIS_RDATA : MIS_PTR;
                            end
                            else if (shift_q == GCALL_ADDR)
                            begin
                                sda_oe_q <= 1'b1;
                                state_q <= MIS_GCALL;
                            end
                            else
                                state_q <= MIS_SKIP; // hs code not acked
                        end
                        MIS_PTR:
                        begin
                            sda_oe_q <= 1'b1;
                            state_q <= MIS_WDATA;
                        end
                        MIS_WDATA:
                        begin
                            sda_oe_q <= 1'b1;
                            if (!byte_idx_q)
                                hi_q <= shift_q;
                            else
                            begin
                                wr_word_q <= {hi_q, shift_q};
                                wr_stb_q <= 1'b1;
                            end
                            byte_idx_q <= ~byte_idx_q;
                        end
                        MIS_RDATA:
                            sda_oe_q <= 1'b0; // master drives ack
                        MIS_GCALL:
                        begin
                            sda_oe_q <= 1'b1;
                            gc_rst_q <= (shift_q == GCALL_RESET);
                            state_q <= MIS_SKIP;
                        end
                        default:
                            state_q <= MIS_SKIP;
                    endcase
                end
                else if (state_q == MIS_RDATA)
                    begin
                        sda_oe_q <= ~shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                    end
            end
        end
    end

    // pointer changes only on the write path
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || gc_rst_q || (wr_stb_q && ptr_q == CFG_PTR && wr_word_q[CFG_RST_BIT]))
            ptr_q <= CFG_PTR;
        else if (state_q == MIS_PTR && scl_fall && bit_q == 4'h8 && !ack_phase_q)
            ptr_q <= shift_q;
    end

    // high-speed flag: master code seen, cleared at stop
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || stop_ev || timeout_q)
            hs_q <= 1'b0;
        else if (state_q == MIS_ADDR && scl_fall && bit_q == 4'h8 && !ack_phase_q &&
                 shift_q[7:3] == HS_CODE)
            hs_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // configuration side effects
    // ------------------------------------------------------------
    logic cfg_wr;
    logic [2:0] new_mode;
    logic [31:0] rec_cnt_q;
    logic cfg_q_valid, start_q, shunt_q, bus_q, ready_q;
    logic [15:0] cfg_q;

    assign cfg_wr = wr_stb_q && ptr_q == CFG_PTR;
    assign new_mode = wr_word_q[MODE_LSB +: 3];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || gc_rst_q || (cfg_wr && wr_word_q[CFG_RST_BIT]))
            cfg_q <= CFG_RESET;
        else if (cfg_wr)
            cfg_q <= wr_word_q;
    end

    // shunt bit 0, bus bit 1, continuous bit 2; averaging counts go with cfg
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || gc_rst_q)
        begin
            start_q <= 1'b0;
            shunt_q <= 1'b0;
            bus_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            shunt_q <= cfg_q[MODE_LSB];
            bus_q <= cfg_q[MODE_LSB + 1];
            if (cfg_wr && !wr_word_q[CFG_RST_BIT] && !wr_word_q[MODE_LSB + 2] &&
                new_mode != MODE_PDOWN)
                start_q <= 1'b1;
            else if ((cfg_wr && new_mode[2] && new_mode != MODE_ADC_OFF) ||
                     (i_conv_done && cfg_q[MODE_LSB + 2] && cfg_q[MODE_LSB +: 3] != MODE_ADC_OFF))
                start_q <= 1'b1; // continuous start and restart
        end
    end

    // recovery after power-down; slow to avoid reading a cold front end
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || cfg_q[MODE_LSB +: 3] == MODE_PDOWN)
        begin
            rec_cnt_q <= 32'h0;
            cfg_q_valid <= i_sys_rst;
        end
        else if (!cfg_q_valid)
        begin
            rec_cnt_q <= rec_cnt_q + 32'h1;
            cfg_q_valid <= (rec_cnt_q + 32'h1 >= 32'(RECOVER_CYCLES));
        end
    end

    // ready flag: set wins over clear
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || gc_rst_q)
            ready_q <= 1'b0;
        else if (i_conv_done)
            ready_q <= 1'b1;
        else if (cfg_wr && new_mode != MODE_PDOWN && new_mode != MODE_ADC_OFF)
            ready_q <= 1'b0;
    end

    // outputs straight from flops, except o_sda_out, which is tied to 0
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_q;
    assign o_ptr = ptr_q;
    assign o_wr_stb = wr_stb_q;
    assign o_wr_word = wr_word_q;
    assign o_cfg = cfg_q;
    assign o_conv_start = start_q;
    assign o_conv_shunt = shunt_q;
    assign o_conv_bus = bus_q;
    assign o_conversion_done_flag = ready_q;
    assign o_results_valid = cfg_q_valid;
    assign o_hs_mode = hs_q;
endmodule

/* bench/mis_slave_props.sv */
module mis_slave_props
    import mis_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int RECOVER_CYCLES = RECOVER_CYC
)(
    input wire logic i_sys_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire logic i_scl, // clock line
    input wire logic i_sda, // data line
    input wire logic o_sda_oe, // data pull
    input wire logic [7:0] o_ptr, // pointer
    input wire logic o_wr_stb, // word strobe
    input wire logic [15:0] o_wr_word, // word
    input wire logic [15:0] o_cfg, // config
    input wire logic o_conv_start, // start
    input wire logic o_conv_shunt, // shunt on
    input wire logic o_conv_bus, // bus on
    input wire logic i_conv_done, // done
    input wire logic o_conversion_done_flag, // ready
    input wire logic o_results_valid, // recovered
    input wire logic o_hs_mode // fast filters
);
    timeunit 1ns;
    timeprecision 100ps;
    int low_cnt_q;
    int inval_cnt_q;
    logic cfg_wr;
    // ----------
    // run lengths
    // ----------
    // counting in the checker keeps long waits out of the repetition operators
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || (i_scl && i_sda))
            low_cnt_q <= 0;
        else
            low_cnt_q <= low_cnt_q + 1;
    end
    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst || o_results_valid || o_cfg[2:0] == MODE_PDOWN)
            inval_cnt_q <= 0;
        else
            inval_cnt_q <= inval_cnt_q + 1;
    end
    assign cfg_wr = o_wr_stb && o_ptr == CFG_PTR && !o_wr_word[CFG_RST_BIT];
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_sys_rst);
    a_cfg_store: assert property (cfg_wr |-> ##[0:3] o_cfg == o_wr_word)
        else $error("config word not stored");
    a_soft_reset: assert property (o_wr_stb && o_ptr == CFG_PTR && o_wr_word[CFG_RST_BIT]
        |-> ##[0:3] o_cfg == CFG_RESET) else $error("soft reset missed");
    a_trig_start: assert property (cfg_wr && !o_wr_word[2] && o_wr_word[1:0] != 2'h0
        |-> ##[0:4] o_conv_start) else $error("no single shot");
    a_ready_clear: assert property (cfg_wr && o_wr_word[1:0] != 2'h0 && !i_conv_done
        |-> ##[1:4] !o_conversion_done_flag) else $error("ready not cleared");
    a_ready_set: assert property (i_conv_done |-> ##[1:2] o_conversion_done_flag)
        else $error("ready not set");
    a_mode_lines: assert property ($stable(o_cfg)[*3] |-> o_conv_shunt == o_cfg[0]
        && o_conv_bus == o_cfg[1]) else $error("mode lines wrong");
    a_wake_recover: assert property ($past(o_cfg[2:0]) == MODE_PDOWN
        && o_cfg[2:0] != MODE_PDOWN |-> ##[0:2] !o_results_valid) else $error("no recovery");
    a_recover_len: assert property ($rose(o_results_valid) |-> inval_cnt_q >= RECOVER_CYCLES - 2
        && inval_cnt_q <= RECOVER_CYCLES + 4) else $error("recovery length wrong");
    a_ack_low_scl: assert property (!o_hs_mode && $changed(o_sda_oe) |-> !i_scl)
        else $error("data changed while clock high");
    a_stop_release: assert property (i_scl && $rose(i_sda)
        |-> ##[1:30] !o_hs_mode && !o_sda_oe) else $error("stop not honoured");
    a_line_timeout: assert property (low_cnt_q > TIMEOUT_CYCLES + 40 |-> !o_sda_oe)
        else $error("timeout ignored");
    c_word: cover property (o_wr_stb);
    c_hs: cover property ($rose(o_hs_mode));
    c_wake: cover property ($fell(o_results_valid));
endmodule
bind mis_slave mis_slave_props #(
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES),
    .RECOVER_CYCLES(RECOVER_CYCLES)
) u_mis_slave_props (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda_oe(o_sda_oe), .o_ptr(o_ptr), .o_wr_stb(o_wr_stb), .o_wr_word(o_wr_word),
    .o_cfg(o_cfg), .o_conv_start(o_conv_start), .o_conv_shunt(o_conv_shunt),
    .o_conv_bus(o_conv_bus), .i_conv_done(i_conv_done),
    .o_conversion_done_flag(o_conversion_done_flag),
    .o_results_valid(o_results_valid), .o_hs_mode(o_hs_mode)
);

/* bench/mis_i2c_master.sv */
module mis_i2c_master (
    output logic o_scl, // clock drive, 1 releases
    output logic o_sda, // data drive, 1 releases
    input wire logic i_sda_line // resolved data line
);
    timeunit 1ns;
    timeprecision 100ps;
    int q = 80; // quarter bit in ns
    // ----------
    // bus master
    // ----------
    // the clock stands still high between frames
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // start or repeated start: data falls while clock is high
    task automatic start();
        o_sda = 1'b1;
        #q o_scl = 1'b1;
        #q o_sda = 1'b0;
        #q o_scl = 1'b0;
        #q;
    endtask
    task automatic stop();
        o_sda = 1'b0;
        #q o_scl = 1'b1;
        #q o_sda = 1'b1;
        #(2 * q);
    endtask
    // data set while low, sampled in mid high
    task automatic xfer(input logic b, output logic r);
        o_sda = b;
        #q o_scl = 1'b1;
        #q r = i_sda_line;
        #q o_scl = 0;
        #q;
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(d[i], r);
        xfer(1'b1, r);
        ack = ~r;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer(1'b1, d[i]);
        xfer(~ack, r);
    endtask
endmodule

/* bench/testbench.sv */
module testbench
    import mis_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TO_CYC = 3000;
    localparam int RC_CYC = 400;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [1:0] strap_lo = 2'h0;
    logic [1:0] strap_hi = 2'h0;
    logic conv_done = 1'b0;
    wire logic m_scl, m_sda, sda_line;
    logic sda_out, sda_oe, wr_stb, conv_start, shunt, bus, rdy, valid, hs;
    logic [7:0] ptr;
    logic [15:0] wr_word, cfg, rd_word, last_word, w;
    logic [6:0] dev;
    logic ack;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_start = 0;
    int dly = 0;
    int n0;
    logic [2:0] modes [8] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    always #2.5 i_sys_clk = ~i_sys_clk;
    assign sda_line = m_sda & (sda_oe ? sda_out : 1'b1);
    assign rd_word = (ptr == CFG_PTR) ? cfg : {ptr, ~ptr};
    mis_slave #(.TIMEOUT_CYCLES(TO_CYC), .RECOVER_CYCLES(RC_CYC)) u_mis_slave (
        .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(m_scl), .i_sda(sda_line),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_select_low_pin(strap_lo),
        .i_addr_select_high_pin(strap_hi), .i_rd_word(rd_word), .o_ptr(ptr),
        .o_wr_stb(wr_stb), .o_wr_word(wr_word), .o_cfg(cfg), .o_conv_start(conv_start),
        .o_conv_shunt(shunt), .o_conv_bus(bus), .i_conv_done(conv_done),
        .o_conversion_done_flag(rdy), .o_results_valid(valid), .o_hs_mode(hs));
    mis_i2c_master mst (.o_scl(m_scl), .o_sda(m_sda), .i_sda_line(sda_line));
    // ----------
    // helpers
    // ----------
    // slow converter stand-in, so a cleared ready flag can be seen before it sets again
    always @(posedge i_sys_clk)
    begin
        #1;
        if (wr_stb)
            last_word = wr_word;
        conv_done = (dly == 1);
        if (dly > 0)
            dly--;
        if (conv_start)
        begin
            n_start++;
            dly = 1000;
        end
        cyc++;
        if (cyc == 100000)
        begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input bit dat, input logic [15:0] d, input bit keep);
        mst.start();
        mst.wbyte({dev, 1'b0}, ack);
        chk(16'(ack), 16'h1);
        mst.wbyte(p, ack);
        chk(16'(ack), 16'h1);
        if (dat)
        begin
            mst.wbyte(d[15:8], ack);
            chk(16'(ack), 16'h1);
            mst.wbyte(d[7:0], ack);
            chk(16'(ack), 16'h1);
        end
        if (!keep)
            mst.stop();
    endtask
    task automatic rd(output logic [15:0] v);
        mst.start();
        mst.wbyte({dev, 1'b1}, ack);
        chk(16'(ack), 16'h1);
        mst.rbyte(v[15:8], 1'b1);
        mst.rbyte(v[7:0], 1'b0);
        mst.stop();
    endtask
    task automatic done_test(input string s);
        $display("test %0s finished", s);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------
    // tests
    // ----------
    initial
    begin
        repeat (12) @(posedge i_sys_clk);
        #1 i_sys_rst = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        // each strap pairing answers its own address, the one with bits 0 and 2 flipped is ignored
        for (int k = 0; k < 16; k++)
        begin
            @(posedge i_sys_clk);
            #1 {strap_hi, strap_lo} = 4'(k);
            dev = {ADDR_UPPER, 4'(k)};
            mst.start();
            mst.wbyte({dev, 1'b0}, ack);
            chk(16'(ack), 16'h1);
            mst.start();
            mst.wbyte({dev ^ 7'h05, 1'b0}, ack);
            chk(16'(ack), 16'h0);
            mst.stop();
        end
        done_test("straps");
        wr(8'h05, 1'b1, 16'ha55a, 1'b1);
        chk(last_word, 16'ha55a);
        chk(16'(ptr), 16'h0005);
        rd(w);
        chk(w, 16'h05fa);
        rd(w);
        chk(w, 16'h05fa);
        wr(8'h07, 1'b0, 16'h0, 1'b1);
        rd(w);
        chk(w, 16'h07f8);
        done_test("words");
        // every mode code except power-down, the first triggered one written twice
        foreach (modes[i])
        begin
            n0 = n_start;
            wr(CFG_PTR, 1'b1, {13'h0, modes[i]}, 1'b0);
            chk(16'({bus, shunt}), 16'(modes[i][1:0]));
            if (!modes[i][2])
                chk(16'(n_start - n0), 16'h1);
        end
        wr(CFG_PTR, 1'b1, 16'h0001, 1'b0);
        chk(16'(rdy), 16'h0);
        repeat (1100) @(posedge i_sys_clk);
        chk(16'(rdy), 16'h1);
        wr(CFG_PTR, 1'b1, 16'h0004, 1'b0);
        chk(16'(rdy), 16'h1);
        wr(CFG_PTR, 1'b1, 16'h0100, 1'b0);
        chk(16'(rdy), 16'h1);
        wr(CFG_PTR, 1'b1, 16'h0007, 1'b0);
        chk(16'(rdy), 16'h0);
        chk(16'(valid), 16'h0);
        repeat (RC_CYC) @(posedge i_sys_clk);
        chk(16'(valid), 16'h1);
        done_test("modes");
        wr(CFG_PTR, 1'b1, 16'h8000, 1'b0);
        chk(cfg, CFG_RESET);
        wr(CFG_PTR, 1'b1, 16'h0003, 1'b0);
        wr(8'h05, 1'b0, 16'h0, 1'b0);
        mst.start();
        mst.wbyte(GCALL_ADDR, ack);
        mst.wbyte(GCALL_RESET, ack);
        mst.stop();
        chk(cfg, CFG_RESET);
        chk(16'(ptr), 16'h0000);
        done_test("resets");
        // fast transfers chained by repeated starts
        mst.start();
        mst.wbyte({HS_CODE, 3'h2}, ack);
        chk(16'(ack), 16'h0);
        chk(16'(hs), 16'h1);
        mst.q = 20;
        wr(8'h05, 1'b0, 16'h0, 1'b1);
        chk(16'(hs), 16'h1);
        rd(w);
        chk(w, 16'h05fa);
        mst.q = 80;
        chk(16'(hs), 16'h0);
        done_test("high speed");
        // clock held low while the slave drives a zero
        mst.start();
        mst.wbyte({dev, 1'b1}, ack);
        repeat (10) @(posedge i_sys_clk);
        chk(16'(sda_oe), 16'h1);
        repeat (TO_CYC + 100) @(posedge i_sys_clk);
        chk(16'(sda_oe), 16'h0);
        mst.stop();
        done_test("timeout");
        give_verdict();
    end
endmodule
